// ### design/spp_pkg.sv
// Package for the six-bit port with neighbour pullup control.
// Assumes a Wishbone classic slave with 32-bit data, registers in the low byte.
package spp_pkg;
    // Byte addresses of the registers on the Wishbone bus
    localparam logic [7:0] SPP_ADDR_PORT_LATCH = 8'h08;
    localparam logic [7:0] SPP_ADDR_NEIGHBOUR_PULLUP = 8'h0f;
    localparam logic [7:0] SPP_ADDR_PORT_DIRECTION = 8'h0c;
    localparam logic [7:0] SPP_ADDR_SERIAL_CTRL = 8'h10;
    // Widths
    localparam int SPP_PORT_W = 6;
    localparam int SPP_NEIGH_W = 8;
    // Pin positions of the shared serial pins
    localparam int SPP_RX_PIN = 1;
    localparam int SPP_TX_PIN = 0;
    // Values after reset
    localparam logic [7:0] SPP_PULLUP_RESET = 8'h00;
    localparam logic [5:0] SPP_DIR_RESET = 6'h00;
    localparam logic SPP_SERIAL_EN_RESET = 1'b0;
endpackage : spp_pkg

// ### design/spp_port.sv
// Six-bit general-purpose port with serial pin sharing and neighbour pullups.
// Assumes a Wishbone classic master, pins synchronised here, one 20 MHz clock.
//
// Operation
// - One pullup enable bit per neighbour pin
// - Output direction forces neighbour pullup off
// - Six pins with latch and direction each
// - Reset leaves port data latches untouched
// - Serial module owns direction of shared pins
// - Direction bit still selects latch or pin read
// - Pin 1 carries serial receive when enabled
// - Pin 0 carries serial transmit when enabled
// - Direction 1 drives pin, 0 floats it
// - Reset clears direction bits; software reads them
// - Read returns latch for output pins
// - Read returns pin level for input pins
// - Writes always update latch, any direction
// - Clearing serial enable returns pins to port
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
module spp_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port pins (output enable low while driving)
    input wire logic [5:0] port_pin_i,
    output logic [5:0] port_pin_o,
    output logic [5:0] port_pin_oe_n_o,
    // Neighbour port direction and resulting pullup controls
    input wire logic [7:0] neighbour_direction_bits_i,
    output logic [7:0] neighbour_pullup_on_o,
    // Serial module side
    input wire logic serial_tx_i,
    input wire logic serial_tx_drive_i,
    output logic serial_rx_o,
    output logic serial_module_enable_o
);
    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [5:0] port_latch_bits; // Data latches, no reset
    logic [5:0] port_direction_bits; // Direction bits
    logic [7:0] neighbour_pullup_bits; // Neighbour pullup enables
    logic serial_module_enable; // Serial enable
    logic latch_loaded; // Checker helper: latch written at least once
    logic [5:0] pin_meta; // First synchroniser stage
    logic [5:0] pin_sync; // Second synchroniser stage
    logic [7:0] ndir_meta; // Neighbour direction first stage
    logic [7:0] ndir_sync; // Neighbour direction second stage

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    // A request is taken only while no answer is pending, so a master that
    // keeps its strobe up one cycle too long is not served twice
    wire req = cyc_i && stb_i && !ack_o; // New request, one ack per cycle
    wire wr_lane0 = req && we_i && sel_i[0]; // Only lane 0 carries data
    wire hit_latch = adr_i == spp_pkg::SPP_ADDR_PORT_LATCH;
    wire hit_pull = adr_i == spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP;
    wire hit_dir = adr_i == spp_pkg::SPP_ADDR_PORT_DIRECTION;
    wire hit_ser = adr_i == spp_pkg::SPP_ADDR_SERIAL_CTRL;
    // Port read merges latch and pin per direction bit
    wire [5:0] port_view = (port_direction_bits & port_latch_bits)
                         | (~port_direction_bits & pin_sync);
    wire [7:0] rd_byte = hit_latch ? {2'b00, port_view} :
                         hit_dir ? {2'b00, port_direction_bits} :
                         hit_pull ? neighbour_pullup_bits :
                         hit_ser ? {7'h00, serial_module_enable} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Pin path: serial enable steals direction of pins 0 and 1
    // Pin 1 is forced to input while the serial module owns it, so the
    // receiver never fights the line whatever the direction bit holds
    logic [5:0] drive_en; // 1 where this block drives the pin
    logic [5:0] drive_val; // Value driven
    always_comb begin
        drive_en = port_direction_bits;
        drive_val = port_latch_bits;
        if (serial_module_enable) begin // clear returns to port
            drive_en[spp_pkg::SPP_TX_PIN] = serial_tx_drive_i;
            drive_val[spp_pkg::SPP_TX_PIN] = serial_tx_i;
            drive_en[spp_pkg::SPP_RX_PIN] = 1'b0; // receive is input
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and neighbour directions
    // Both arrive from outside this clock domain; only the second stage is
    // read, which costs two cycles of latency on every pin read
    always_ff @(posedge clk_i) begin
        pin_meta <= port_pin_i;
        pin_sync <= pin_meta;
        ndir_meta <= neighbour_direction_bits_i;
        ndir_sync <= ndir_meta;
    end

    ////////////////////////////////////////////////////////////////////////
    // Data latches: never reset, written whatever the direction
    always_ff @(posedge clk_i) begin
        if (wr_lane0 && hit_latch) begin
            port_latch_bits <= dat_i[5:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checker helper: marks the latch as loaded after its first write.
    // Left without reset on purpose, like the latch it watches, so that the
    // hold check also covers a reset in mid-run.
    always_ff @(posedge clk_i) begin
        if (wr_lane0 && hit_latch) begin
            latch_loaded <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_direction_bits <= spp_pkg::SPP_DIR_RESET;
            neighbour_pullup_bits <= spp_pkg::SPP_PULLUP_RESET;
            serial_module_enable <= spp_pkg::SPP_SERIAL_EN_RESET;
        end else if (wr_lane0) begin
            if (hit_dir) begin
                port_direction_bits <= dat_i[5:0];
            end
            if (hit_pull) begin
                neighbour_pullup_bits <= dat_i[7:0];
            end
            if (hit_ser) begin
                serial_module_enable <= dat_i[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait state, unmapped reads return zero
    // Read data is zero outside a read answer so several slaves may be OR-ed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= (req && !we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin and serial outputs
    // Registered so pins never see decode glitches; costs one cycle of delay
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_pin_o <= 6'h00;
            port_pin_oe_n_o <= 6'h3f;
            neighbour_pullup_on_o <= 8'h00;
            serial_rx_o <= 1'b1;
            serial_module_enable_o <= 1'b0;
        end else begin
            port_pin_o <= drive_val;
            port_pin_oe_n_o <= ~drive_en;
            neighbour_pullup_on_o <= neighbour_pullup_bits & ~ndir_sync;
            serial_rx_o <= serial_module_enable ? pin_sync[spp_pkg::SPP_RX_PIN] : 1'b1;
            serial_module_enable_o <= serial_module_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_dir_write;
        wr_lane0 && hit_dir;
    endsequence
    property p_pullup_off;
        @(posedge clk_i) disable iff (rst_i) ndir_sync != 8'h00 |=> (neighbour_pullup_on_o & $past(ndir_sync)) == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pullup on for output pin");
    property p_pullup_follow;
        @(posedge clk_i) disable iff (rst_i) 1'b1 |=> neighbour_pullup_on_o == ($past(neighbour_pullup_bits) & ~$past(ndir_sync));
    endproperty
    a_pullup_follow: assert property (p_pullup_follow) else $error("pullup output wrong");
    property p_dir_write;
        @(posedge clk_i) disable iff (rst_i) s_dir_write |=> port_direction_bits == $past(dat_i[5:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");
    property p_latch_write;
        @(posedge clk_i) wr_lane0 && hit_latch |=> port_latch_bits == $past(dat_i[5:0]);
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("latch write lost");
    property p_tx_drive;
        @(posedge clk_i) disable iff (rst_i) serial_module_enable |=> port_pin_o[0] == $past(serial_tx_i);
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("transmit not on pin 0");
    property p_rx_input;
        @(posedge clk_i) disable iff (rst_i) serial_module_enable |=> port_pin_oe_n_o[1];
    endproperty
    a_rx_input: assert property (p_rx_input) else $error("receive pin driven");
    property p_gpio_back;
        @(posedge clk_i) disable iff (rst_i) !serial_module_enable |=> port_pin_oe_n_o == ~$past(port_direction_bits);
    endproperty
    a_gpio_back: assert property (p_gpio_back) else $error("pins not under direction bits");
    property p_read_view;
        @(posedge clk_i) disable iff (rst_i) req && !we_i && hit_latch |=> ack_o && dat_o[7:6] == 2'b00
            && dat_o[5:0] == (($past(port_direction_bits) & $past(port_latch_bits))
            | (~$past(port_direction_bits) & $past(pin_sync)));
    endproperty
    a_read_view: assert property (p_read_view) else $error("port read wrong");
    property p_reset_dir;
        @(posedge clk_i) rst_i |=> port_direction_bits == 6'h00 ##1 port_pin_oe_n_o == 6'h3f || !rst_i;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction not cleared by reset");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake checks
    // A taken request: strobe up while no answer is pending
    sequence s_bus_take;
        req;
    endsequence
    // The answer that follows one cycle later
    sequence s_bus_answer;
        ack_o;
    endsequence
    // Every taken request gets its acknowledge one cycle later
    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i) s_bus_take |=> s_bus_answer;
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
    // Acknowledge stands for one cycle only, so a held strobe is not taken twice
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i) s_bus_answer |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");

    ////////////////////////////////////////////////////////////////////////
    // Register read-back checks
    // Reads of the direction and pullup registers
    sequence s_dir_read;
        req && !we_i && hit_dir;
    endsequence
    sequence s_pull_read;
        req && !we_i && hit_pull;
    endsequence
    // Direction bits read back with the 26 unused bits as zero
    property p_dir_read;
        @(posedge clk_i) disable iff (rst_i) s_dir_read |=> dat_o == {26'h0, $past(port_direction_bits)};
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("direction read wrong");
    // All eight pullup enable bits read back as written
    property p_pull_read;
        @(posedge clk_i) disable iff (rst_i) s_pull_read |=> dat_o == {24'h0, $past(neighbour_pullup_bits)};
    endproperty
    a_pull_read: assert property (p_pull_read) else $error("pullup read wrong");
    // A write with lane 0 disabled leaves the pullup bits alone
    property p_lane_off;
        @(posedge clk_i) disable iff (rst_i) req && we_i && !sel_i[0] |=> $stable(neighbour_pullup_bits);
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("write without lane 0 landed");
    // Reset clears the pullup enables
    property p_pull_reset;
        @(posedge clk_i) rst_i |=> neighbour_pullup_bits == spp_pkg::SPP_PULLUP_RESET;
    endproperty
    a_pull_reset: assert property (p_pull_reset) else $error("pullup enables not cleared by reset");

    ////////////////////////////////////////////////////////////////////////
    // Latch and pin checks
    // Once loaded, reset alone never disturbs the latch contents
    property p_latch_hold;
        @(posedge clk_i) latch_loaded && rst_i && !(wr_lane0 && hit_latch)
            |=> port_latch_bits == $past(port_latch_bits);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed by reset");
    // Plain port pins follow their direction bits one cycle later
    property p_plain_oe;
        @(posedge clk_i) disable iff (rst_i) 1'b1 |=> port_pin_oe_n_o[5:2] == ~$past(port_direction_bits[5:2]);
    endproperty
    a_plain_oe: assert property (p_plain_oe) else $error("plain pin enable wrong");
    // While serial is enabled, the serial module alone decides whether pin 0 is driven
    property p_tx_oe;
        @(posedge clk_i) disable iff (rst_i) serial_module_enable
            |=> port_pin_oe_n_o[0] == !$past(serial_tx_drive_i);
    endproperty
    a_tx_oe: assert property (p_tx_oe) else $error("transmit pin enable wrong");
    // Receive output follows the synchronised pin 1 while enabled
    property p_rx_follow;
        @(posedge clk_i) disable iff (rst_i) serial_module_enable
            |=> serial_rx_o == $past(pin_sync[spp_pkg::SPP_RX_PIN]);
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("receive output wrong");
    // Receive output idles high once the pins are handed back
    property p_rx_idle;
        @(posedge clk_i) disable iff (rst_i) !serial_module_enable |=> serial_rx_o;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("receive output not idle");
    // Serial enable writes land on bit 0
    sequence s_ser_write;
        wr_lane0 && hit_ser;
    endsequence
    property p_ser_write;
        @(posedge clk_i) disable iff (rst_i) s_ser_write |=> serial_module_enable == $past(dat_i[0]);
    endproperty
    a_ser_write: assert property (p_ser_write) else $error("serial enable write lost");
    // Enable output mirrors the register one cycle later
    property p_ser_out;
        @(posedge clk_i) disable iff (rst_i) 1'b1 |=> serial_module_enable_o == $past(serial_module_enable);
    endproperty
    a_ser_out: assert property (p_ser_out) else $error("serial enable output wrong");
endmodule : spp_port

// ### test/spp_board.sv
// Board model: external levels on the six pins and the serial transmitter.
// Assumes the bench sets the external levels and the transmit request.
`timescale 1ns/1ps
module spp_board (
    // Design side
    input wire logic [5:0] dut_pin_i,
    input wire logic [5:0] dut_oe_n_i,
    // Bench side
    input wire logic [5:0] ext_i,
    input wire logic tx_i,
    input wire logic tx_drv_i,
    // Towards the design
    output logic [5:0] pin_o,
    output logic serial_tx_o,
    output logic serial_tx_drive_o
);
    // Driven pins show the design level, released pins the board level
    assign pin_o = (~dut_oe_n_i & dut_pin_i) | (dut_oe_n_i & ext_i);
    // Serial transmitter asks for pin 0 only when it wants to drive
    assign serial_tx_o = tx_i;
    assign serial_tx_drive_o = tx_drv_i;
endmodule : spp_board

// ### test/test_six_bit_port_with_pullup_ctl.sv
// Bench for the six-bit port: Wishbone tasks and pin checks.
// Assumes spp_port and the board model; one 20 MHz clock.
`timescale 1ns/1ps
module test_six_bit_port_with_pullup_ctl;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, serial_rx_o, serial_module_enable_o;
    logic [7:0] adr_i, neighbour_direction_bits_i, neighbour_pullup_on_o;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o;
    logic [5:0] port_pin_i, port_pin_o, port_pin_oe_n_o, ext;
    logic serial_tx_i, serial_tx_drive_i, tx, tx_drv;
    int errors = 0;
    int checks_done = 0;
    spp_port DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
        .port_pin_i, .port_pin_o, .port_pin_oe_n_o, .neighbour_direction_bits_i,
        .neighbour_pullup_on_o, .serial_tx_i, .serial_tx_drive_i, .serial_rx_o, .serial_module_enable_o);
    spp_board board (.dut_pin_i(port_pin_o), .dut_oe_n_i(port_pin_oe_n_o), .ext_i(ext), .tx_i(tx),
        .tx_drv_i(tx_drv), .pin_o(port_pin_i), .serial_tx_o(serial_tx_i), .serial_tx_drive_o(serial_tx_drive_i));
    ////////////////////////////////////////////////////////////////////////////
    // Comparison and verdict
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task end_of_test;
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    // One classic cycle; holds the request until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        check({31'h0, ack_o}, 32'h1);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : wb
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////
    // Clock and watchdog; the run needs well under a thousand cycles
    initial begin clk_i = 1'b0; forever #25 clk_i = ~clk_i; end
    initial begin #2000000; errors++; end_of_test(); end
    // Main sequence
    initial begin
        {rst_i, cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {4'h8, 8'h00, 32'h0, 4'hf};
        {ext, tx, tx_drv, neighbour_direction_bits_i} = {6'h15, 2'b00, 8'hf0};
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'h0);
        rd(spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP, 32'h0);
        wr(spp_pkg::SPP_ADDR_PORT_LATCH, 32'hffff_ffea);
        rd(spp_pkg::SPP_ADDR_PORT_LATCH, 32'h15);
        wr(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'hff);
        rd(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'h3f);
        rd(spp_pkg::SPP_ADDR_PORT_LATCH, 32'h2a);
        check({26'h0, port_pin_oe_n_o}, 32'h0);
        check({26'h0, port_pin_o}, 32'h2a);
        wr(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'h0f);
        repeat (4) @(posedge clk_i);
        rd(spp_pkg::SPP_ADDR_PORT_LATCH, 32'h1a);
        check({26'h0, port_pin_oe_n_o}, 32'h30);
        wr(spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP, 32'h5a5);
        rd(spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP, 32'ha5);
        // A write without lane 0 must be ignored
        sel_i <= 4'he;
        wr(spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP, 32'h00);
        sel_i <= 4'hf;
        rd(spp_pkg::SPP_ADDR_NEIGHBOUR_PULLUP, 32'ha5);
        check({24'h0, neighbour_pullup_on_o}, 32'h05);
        // Serial owns pins 0 and 1; transmit high differs from latch bit 0
        {tx, tx_drv} <= 2'b11;
        wr(spp_pkg::SPP_ADDR_SERIAL_CTRL, 32'h1);
        repeat (4) @(posedge clk_i);
        check({26'h0, port_pin_oe_n_o}, 32'h32);
        check({31'h0, port_pin_o[0]}, 32'h1);
        check({30'h0, serial_rx_o, serial_module_enable_o}, 32'h1);
        rd(spp_pkg::SPP_ADDR_PORT_LATCH, 32'h1a);
        tx_drv <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({26'h0, port_pin_oe_n_o}, 32'h33);
        wr(spp_pkg::SPP_ADDR_SERIAL_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        check({25'h0, serial_rx_o, port_pin_oe_n_o}, 32'h70);
        rd(8'h20, 32'h0);
        // Reset in mid-run clears direction but keeps the latch
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'h0);
        wr(spp_pkg::SPP_ADDR_PORT_DIRECTION, 32'h3f);
        rd(spp_pkg::SPP_ADDR_PORT_LATCH, 32'h2a);
        end_of_test();
    end
endmodule : test_six_bit_port_with_pullup_ctl
